// File: design/dac_readback_pkg.sv
package dac_readback_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int         CMD_W       = 24;     // Command word length
    localparam int         FRAME_W     = 32;     // Command plus check byte
    localparam int         RW_BIT      = 23;     // High for a read
    localparam int         ADDR_HI_BIT = 22;     // Device address, high
    localparam int         ADDR_LO_BIT = 21;     // Device address, low
    localparam int         SEL_MSB     = 20;     // Read-select field
    localparam int         SEL_LSB     = 16;
    localparam logic [7:0] LEAD_BYTE   = 8'h00;  // Filler ahead of data
    localparam logic [7:0] CRC_POLY    = 8'h07;  // Check polynomial
    localparam logic [7:0] CRC_INIT    = 8'h00;  // Check seed

    // ------------------------------------------------------------
    // Read-select groups: code[4:2] picks group, code[1:0] channel, or register in GRP_MISC
    // ------------------------------------------------------------
    localparam logic [2:0] GRP_DATA  = 3'h0;
    localparam logic [2:0] GRP_CTRL  = 3'h1;
    localparam logic [2:0] GRP_GAIN  = 3'h2;
    localparam logic [2:0] GRP_OFFS  = 3'h3;
    localparam logic [2:0] GRP_CLR   = 3'h4;
    localparam logic [2:0] GRP_SLEW  = 3'h5;
    localparam logic [2:0] GRP_MISC  = 3'h6;
    localparam logic [1:0] MISC_STAT = 2'h0;
    localparam logic [1:0] MISC_MAIN = 2'h1;
    localparam logic [1:0] MISC_DCDC = 2'h2;

    // ------------------------------------------------------------
    // Slew control word and status word fields
    // ------------------------------------------------------------
    localparam int         SLEW_EN_BIT = 12;     // slew_enable
    localparam int         RATE_MSB    = 6;      // slew_update_rate
    localparam int         STEP_MSB    = 2;      // slew_step_size
    localparam int         ST_TOGGLE   = 11;
    localparam int         ST_PEC      = 10;
    localparam int         ST_RAMP     = 9;
    localparam int         ST_OTEMP    = 8;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // Register contents held elsewhere in the device
    typedef struct packed {
        logic [3:0][15:0] data;
        logic [3:0][15:0] ctrl;
        logic [3:0][15:0] gain;
        logic [3:0][15:0] offs;
        logic [3:0][15:0] clr;
        logic [3:0][15:0] slew;
        logic [15:0]      main;
        logic [15:0]      dcdc;
    } reg_view_s;

    // Per-channel analog monitor flags, bit 0 is channel A, plus the single over_temp flag
    typedef struct packed {
        logic [3:0] conv_fail;
        logic [3:0] current_mode;
        logic [3:0] vout_fault;
        logic [3:0] iout_fault;
        logic [3:0] ramping;
        logic       over_temp;
    } analog_s;

    // Check byte over a 24-bit word, MSB first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

endpackage

// File: design/dac_readback_and_status.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] Read command: flag, address, select, ignored data
// [R2] Codes 0-3 return channel data registers
// [R3] Codes 4-7 return channel control registers
// [R4] Codes 8-11 return channel gain registers
// [R5] Codes 12-15 return channel offset registers
// [R6] Codes 16-19 return channel clear-code registers
// [R7] Codes 20-23 return channel slew registers
// [R8] Codes 24-26: status, main, converter control
// [R9] Host sends read or no-op next frame
// [R10] Answer reads only on matching strapped address
// [R11] Slew word: zeros, enable, rate, step fields
// [R12] Status register cannot be written
// [R13] Status-every-write set: status shifts every write
// [R14] Otherwise status only via two-frame read
// [R15] Status bit layout as listed
// [R16] Current mode: converter flag sets current fault
// [R17] Voltage mode: converter flag on regulation failure
// [R18] Converter flag alone never asserts fault pin
// [R19] 24 bits out: 8 filler then 16 data
// [R20] Check mode: 32 bits, 8 check bits appended
// [R21] Frame-check error reflects last received word
// [R22] Ramp active while enabled channel still ramps
// [R23] Codes above 26 return harmless zero
module dac_readback_and_status
    import dac_readback_pkg::*;
(
    // System clock and reset
    input  wire logic      clk,
    input  wire logic      reset,
    // Serial link
    input  wire logic      sclk,
    input  wire logic      sync_n,
    input  wire logic      sdin,
    output var  logic      sdo,
    // Address strap pins
    input  wire logic      device_addr_high,
    input  wire logic      device_addr_low,
    // Device state on the system clock
    input  wire reg_view_s regs,
    input  wire analog_s   analog,
    input  wire logic      status_on_every_write,
    input  wire logic      pec_enable,
    input  wire logic      user_toggle,
    // Results
    output var  logic [15:0] status,
    output var  logic        fault_pin_out,
    output var  logic        fault_pin_oe_n
);

    // ------------------------------------------------------------
    // Link side, receive on falling sclk
    // ------------------------------------------------------------
    logic [5:0]  rx_cnt;     // Bits seen this frame
    logic [31:0] rx_sh;      // Incoming shift register
    logic [31:0] rx_word;    // Held word for the system side
    logic        rx_len32;   // Held word carried a check byte
    logic        rx_tog;     // Flips once per held word

    // Bit counter, cleared whenever the frame is idle
    always_ff @(negedge sclk or posedge sync_n or posedge reset) begin
        if (reset || sync_n) begin
            rx_cnt <= 6'h00;
        end else if (rx_cnt != 6'h20) begin
            rx_cnt <= rx_cnt + 6'h01;
        end
    end

    // Shift in MSB first
    always_ff @(negedge sclk) begin
        rx_sh <= {rx_sh[30:0], sdin};
    end

    // Hold the word after bit 24 and bit 32; stays put for many
    // sclk periods so the system side can read it after the toggle
    always_ff @(negedge sclk or posedge reset) begin
        if (reset) begin
            rx_word  <= 32'h0000_0000;
            rx_len32 <= 1'b0;
            rx_tog   <= 1'b0;
        end else if (!sync_n && (rx_cnt == 6'h17 || rx_cnt == 6'h1f)) begin
            rx_word  <= {rx_sh[30:0], sdin};
            rx_len32 <= (rx_cnt == 6'h1f);
            rx_tog   <= ~rx_tog;
        end
    end

    // ------------------------------------------------------------
    // System side, word arrival and strap synchronisers
    // ------------------------------------------------------------
    logic       rx_tog_meta;   // First stage
    logic       rx_tog_sync;   // Second stage
    logic       rx_tog_seen;   // Last toggle handled
    logic [1:0] addr_meta;     // Strap first stage
    logic [1:0] addr_sync;     // Strap second stage

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_tog_meta <= 1'b0;
            rx_tog_sync <= 1'b0;
            rx_tog_seen <= 1'b0;
            addr_meta   <= 2'h0;
            addr_sync   <= 2'h0;
        end else begin
            rx_tog_meta <= rx_tog;
            rx_tog_sync <= rx_tog_meta;
            rx_tog_seen <= rx_tog_sync;
            addr_meta   <= {device_addr_high, device_addr_low};
            addr_sync   <= addr_meta;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic        acc;       // Complete word of the expected length
    logic [23:0] cmd;       // Command part of that word
    logic        pec_bad;   // Check byte mismatch
    logic        is_read;   // Accepted read for this device
    logic [4:0]  sel;       // Read-select code
    logic [15:0] sel_val;   // Addressed register

    // Words of the wrong length for the mode are dropped; in check
    // mode the 24-bit capture of every frame is such a word
    assign acc     = (rx_tog_sync ^ rx_tog_seen) && (rx_len32 == pec_enable);
    assign cmd     = rx_len32 ? rx_word[31:8] : rx_word[23:0];
    assign pec_bad = rx_len32 && (crc8(cmd) != rx_word[7:0]);  // [R21]
    assign sel     = cmd[SEL_MSB:SEL_LSB];  // [R1]
    // Low data bits are ignored on a read
    assign is_read = cmd[RW_BIT] && !pec_bad  // [R1]
                  && ({cmd[ADDR_HI_BIT], cmd[ADDR_LO_BIT]} == addr_sync);  // [R10]

    // Register select
    always_comb begin
        sel_val = 16'h0000;
        case (sel[4:2])
            GRP_DATA: sel_val = regs.data[sel[1:0]];  // [R2]
            GRP_CTRL: sel_val = regs.ctrl[sel[1:0]];  // [R3]
            GRP_GAIN: sel_val = regs.gain[sel[1:0]];  // [R4]
            GRP_OFFS: sel_val = regs.offs[sel[1:0]];  // [R5]
            GRP_CLR:  sel_val = regs.clr[sel[1:0]];   // [R6]
            GRP_SLEW: sel_val = regs.slew[sel[1:0]];  // [R7]
            GRP_MISC: begin
                case (sel[1:0])
                    MISC_STAT: sel_val = status;      // [R8]
                    MISC_MAIN: sel_val = regs.main;   // [R8]
                    MISC_DCDC: sel_val = regs.dcdc;   // [R8]
                    default:   sel_val = 16'h0000;    // [R23]
                endcase
            end
            default: sel_val = 16'h0000;  // [R23]
        endcase
    end

    // ------------------------------------------------------------
    // Status register and fault pin
    // ------------------------------------------------------------
    logic       pec_err;    // Last word failed its check
    logic       ramp_act;   // Some enabled channel still slews
    logic [3:0] iout_bits;  // Current faults incl. compliance loss

    // Error follows each accepted check-mode word
    always_ff @(posedge clk) begin
        if (reset) begin
            pec_err <= 1'b0;
        end else if (acc && rx_len32) begin
            pec_err <= pec_bad;  // [R21]
        end
    end

    // Only the enable bit of each slew word matters here
    always_comb begin
        ramp_act = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ramp_act = ramp_act || (regs.slew[i][SLEW_EN_BIT] && analog.ramping[i]);  // [R11] [R22]
        end
    end

    // Compliance loss in current mode also marks the current fault
    assign iout_bits = analog.iout_fault | (analog.conv_fail & analog.current_mode);  // [R16]

    // Built only from device state; nothing on the link writes it
    always_ff @(posedge clk) begin
        if (reset) begin
            status <= STATUS_RST;
        end else begin
            status <= {analog.conv_fail,  // [R15] [R16] [R17]
                       user_toggle, pec_err, ramp_act, analog.over_temp,
                       analog.vout_fault, iout_bits};  // [R12] [R15]
        end
    end

    // Open-drain fault: converter flags deliberately left out
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_pin_out  <= 1'b0;
            fault_pin_oe_n <= 1'b1;
        end else begin
            fault_pin_out  <= 1'b0;
            fault_pin_oe_n <= !(|analog.vout_fault || |analog.iout_fault
                               || pec_err || analog.over_temp);  // [R18]
        end
    end

    // ------------------------------------------------------------
    // Answer word for the next frame
    // ------------------------------------------------------------
    logic [31:0] tx_word;  // Filler, data, check byte
    logic        tx_tog;   // Flips once per new answer
    logic [15:0] ans;      // Data part of the answer

    // A read answers in the following frame; otherwise status
    // goes out only when status-on-every-write is set
    always_comb begin
        if (is_read) begin
            ans = sel_val;  // [R9]
        end else if (status_on_every_write) begin
            ans = status;  // [R13]
        end else begin
            ans = 16'h0000;  // [R14]
        end
    end

    // Refreshed once per accepted word, so the snapshot never moves
    // while a frame is being shifted out
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_word <= 32'h0000_0000;
            tx_tog  <= 1'b0;
        end else if (acc) begin
            tx_word <= {LEAD_BYTE, ans, crc8({LEAD_BYTE, ans})};  // [R19] [R20]
            tx_tog  <= ~tx_tog;
        end
    end

    // ------------------------------------------------------------
    // Link side, transmit on rising sclk
    // ------------------------------------------------------------
    logic        tx_tog_meta;  // First stage
    logic        tx_tog_sync;  // Second stage
    logic        tx_tog_seen;  // Last answer taken
    logic [31:0] tx_local;     // Answer copy in the link domain
    logic [5:0]  tx_cnt;       // Bits sent this frame

    // Sclk only runs inside frames; the eight filler bits give the
    // crossing time to land before data bits are needed
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            tx_tog_meta <= 1'b0;
            tx_tog_sync <= 1'b0;
            tx_tog_seen <= 1'b0;
            tx_local    <= 32'h0000_0000;
        end else begin
            tx_tog_meta <= tx_tog;
            tx_tog_sync <= tx_tog_meta;
            tx_tog_seen <= tx_tog_sync;
            if (tx_tog_sync ^ tx_tog_seen) begin
                tx_local <= tx_word;
            end
        end
    end

    // Bit counter, cleared between frames
    always_ff @(posedge sclk or posedge sync_n or posedge reset) begin
        if (reset || sync_n) begin
            tx_cnt <= 6'h00;
        end else if (tx_cnt != 6'h20) begin
            tx_cnt <= tx_cnt + 6'h01;
        end
    end

    // MSB first; up to 32 bits whatever the mode, then low
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            sdo <= 1'b0;
        end else if (tx_cnt < 6'h20) begin
            sdo <= tx_local[5'(6'h1f - tx_cnt)];  // [R19] [R20]
        end else begin
            sdo <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_read_data: assert property (@(posedge clk) disable iff (reset)  // [R2]
        acc && is_read && sel[4:2] == GRP_DATA |=> tx_word[23:8] == $past(regs.data[sel[1:0]]))
        else $error("data readback wrong");
    a_read_ctrl: assert property (@(posedge clk) disable iff (reset)  // [R3]
        acc && is_read && sel[4:2] == GRP_CTRL |=> tx_word[23:8] == $past(regs.ctrl[sel[1:0]]))
        else $error("control readback wrong");
    a_read_gain: assert property (@(posedge clk) disable iff (reset)  // [R4]
        acc && is_read && sel[4:2] == GRP_GAIN |=> tx_word[23:8] == $past(regs.gain[sel[1:0]]))
        else $error("gain readback wrong");
    a_read_slew: assert property (@(posedge clk) disable iff (reset)  // [R7]
        acc && is_read && sel[4:2] == GRP_SLEW |=> tx_word[23:8] == $past(regs.slew[sel[1:0]]))
        else $error("slew readback wrong");
    a_read_unused: assert property (@(posedge clk) disable iff (reset)  // [R23]
        acc && is_read && sel > 5'h1a |=> tx_word[23:8] == 16'h0000)
        else $error("unused code not zero");
    a_addr_mismatch: assert property (@(posedge clk) disable iff (reset)  // [R10]
        acc && !is_read && !status_on_every_write |=> tx_word[23:8] == 16'h0000)
        else $error("answer without matching read");
    a_status_on_every_write_write: assert property (@(posedge clk) disable iff (reset)  // [R13]
        acc && !cmd[RW_BIT] && status_on_every_write |=> tx_word[23:8] == $past(status))
        else $error("status not sent on write");
    a_pec_flag: assert property (@(posedge clk) disable iff (reset)  // [R21]
        acc && rx_len32 |-> ##2 status[ST_PEC] == $past(pec_bad, 2))
        else $error("frame check flag wrong");
    a_conv_no_fault: assert property (@(posedge clk) disable iff (reset)  // [R18]
        analog.vout_fault == 4'h0 && analog.iout_fault == 4'h0 && !analog.over_temp && !pec_err
        |=> fault_pin_oe_n)
        else $error("fault pin driven without fault");
    a_iout_conv: assert property (@(posedge clk) disable iff (reset)  // [R16]
        |(analog.conv_fail & analog.current_mode) |=> |(status[15:12] & status[3:0]))
        else $error("compliance loss not on current fault");
    a_tx_check: assert property (@(posedge clk) disable iff (reset)  // [R20]
        tx_word[7:0] == crc8(tx_word[31:8]))
        else $error("answer check byte wrong");

    c_read_status: cover property (@(posedge clk) disable iff (reset)
        acc && is_read && sel == 5'h18);
    c_frame_check_error: cover property (@(posedge clk) disable iff (reset)
        acc && pec_bad);
    c_status_on_every_write: cover property (@(posedge clk) disable iff (reset)
        acc && !cmd[RW_BIT] && status_on_every_write);

endmodule

`default_nettype wire

// File: verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host controller on the serial link
// ------------------------------------------------------------
module spi_host_model
    import dac_readback_pkg::*;
(
    // Link pins
    output var  logic sclk,
    output var  logic sync_n,
    output var  logic sdin,
    input  wire logic sdo
);
    localparam int HALF = 32;  // 64 ns link period

    // Idle link: frame sync high, clock parked low
    initial begin
        sclk   = 1'b0;
        sync_n = 1'b1;
        sdin   = 1'b0;
    end

    // Check byte over 24 bits, MSB first; kept apart from the device's own copy
    function automatic logic [7:0] chk(input logic [23:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // One frame; bad flips a check bit on purpose; gap sets how slow the host is
    task automatic xfer(input logic [23:0] w, input logic pec, input logic bad, input int gap,
                        output logic [31:0] cap);
        logic [31:0] word;
        int          n;
        word   = {w, chk(w) ^ {7'h00, bad}};
        n      = pec ? 32 : 24;
        cap    = '0;
        #11 sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            // Data moves a quarter period after the falling edge, clear of sampling
            sdin = word[31 - i];
            #(HALF / 2) sclk = 1'b1;
            #HALF cap = {cap[30:0], sdo};
            sclk = 1'b0;
            #(HALF / 2);
        end
        #11 sync_n = 1'b1;
        // Released data line must not look like a held bit
        sdin = ~sdin;
        // Clock stays parked between command and follow-up frame
        #gap;
    endtask
endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dac_readback_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;              // System clock
    logic        reset;                   // Reset, synchronous on clk, asynchronous on the link-side flops except rx_sh, which has no reset
    wire  logic  sclk;                    // Link clock from host
    wire  logic  sync_n;                  // Frame sync
    wire  logic  sdin;                    // Host to device
    wire  logic  sdo;                     // Device to host
    logic        device_addr_high = 1'b0; // Strapped address 1
    logic        device_addr_low  = 1'b1;
    reg_view_s   regs;                    // Register contents
    analog_s     analog;                  // Monitor flags
    logic        status_on_every_write;
    logic        pec_enable;
    logic        user_toggle;
    logic [15:0] status;
    logic        fault_pin_out;
    logic        fault_pin_oe_n;
    logic [31:0] cap;                     // Bits the host sampled
    int          bad_count = 0;
    int          tests_run = 0;
    typedef struct { logic [4:0] code; logic [15:0] exp; } row_s;
    row_s        rows[32];                // Read code beside expected answer
    localparam logic [23:0] NOP = 24'h3ce000;

    always #5 clk = ~clk;

    dac_readback_and_status dac_readback_and_status_i (
        .clk(clk), .reset(reset), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo),
        .device_addr_high(device_addr_high), .device_addr_low(device_addr_low),
        .regs(regs), .analog(analog), .status_on_every_write(status_on_every_write),
        .pec_enable(pec_enable), .user_toggle(user_toggle), .status(status),
        .fault_pin_out(fault_pin_out), .fault_pin_oe_n(fault_pin_oe_n)
    );

    spi_host_model spi_host_model_i (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Frame at the current length; answer field picked by mode
    task automatic frame(input logic [23:0] w, input logic bad, output logic [15:0] d);
        spi_host_model_i.xfer(w, pec_enable, bad, 200, cap);
        d = pec_enable ? cap[23:8] : cap[15:0];
    endtask

    // Read command; ignored low bits left non-zero on purpose
    function automatic logic [23:0] rd(input logic [1:0] a, input logic [4:0] c);
        return {1'b1, a, c, 16'hc3a5};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, well past the roughly 81 us the tests need
    initial begin
        #300_000;
        bad_count++;
        $display("watchdog expired");
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] d;
        logic [15:0] e;
        // Start low so the link-side flops see a real rising edge
        reset                 = 1'b0;
        analog                = '0;
        status_on_every_write = 1'b0;
        pec_enable            = 1'b0;
        user_toggle           = 1'b1;
        // Distinct contents per register; channel D has slewing off
        for (int c = 0; c < 4; c++) begin
            regs.data[c] = 16'h1a00 + 16'(c);
            regs.ctrl[c] = 16'h2b10 + 16'(c);
            regs.gain[c] = 16'h3c20 + 16'(c);
            regs.offs[c] = 16'h4d30 + 16'(c);
            regs.clr[c]  = 16'h5e40 + 16'(c);
            regs.slew[c] = {3'b000, c != 3, 5'h00, 4'h9, 3'(c)};
        end
        regs.main = 16'h6f01;
        regs.dcdc = 16'h7002;
        @(negedge clk);
        reset = 1'b1;
        // Reset values seen while reset is held
        repeat (5) @(negedge clk);
        check("reset status", status, STATUS_RST);
        check("reset fault enable", {15'h0, fault_pin_oe_n}, 16'h0001);
        check("reset sdo", {15'h0, sdo}, 16'h0000);
        @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        $display("test reset done");

        // Table of every read code with the answer the decode must give
        for (int k = 0; k < 32; k++) begin
            case (k / 4)
                0: e = regs.data[k % 4];
                1: e = regs.ctrl[k % 4];
                2: e = regs.gain[k % 4];
                3: e = regs.offs[k % 4];
                4: e = regs.clr[k % 4];
                5: e = regs.slew[k % 4];
                default: e = (k == 24) ? 16'h0800 : (k == 25) ? regs.main
                             : (k == 26) ? regs.dcdc : 16'h0000;
            endcase
            rows[k] = '{5'(k), e};
        end
        // Reads back to back: each frame carries the previous answer
        frame(rd(2'b01, rows[0].code), 1'b0, d);
        for (int k = 1; k <= 32; k++) begin
            frame((k < 32) ? rd(2'b01, rows[k % 32].code) : NOP, 1'b0, d);
            check("readback data", d, rows[k - 1].exp);
            check("filler byte", {8'h00, cap[23:16]}, {8'h00, LEAD_BYTE});
        end
        $display("test readback table done");

        // Example word, then a read aimed at another device
        frame(24'ha80000, 1'b0, d);
        frame(rd(2'b10, 5'd8), 1'b0, d);
        check("example gain read", d, regs.gain[0]);
        frame(NOP, 1'b0, d);
        check("foreign address read", d, 16'h0000);
        $display("test address done");

        // Converter flags in both modes, fault pin only on real faults
        @(negedge clk);
        analog = '{conv_fail: 4'h5, current_mode: 4'h1, default: '0};
        repeat (3) @(negedge clk);
        check("converter flags", status, 16'h5801);
        check("fault pin idle", {15'h0, fault_pin_oe_n}, 16'h0001);
        analog.vout_fault = 4'h2;
        analog.ramping    = 4'h8;
        analog.over_temp  = 1'b1;
        repeat (3) @(negedge clk);
        check("ramp on disabled channel", status, 16'h5921);
        check("fault pin active", {15'h0, fault_pin_oe_n}, 16'h0000);
        check("fault pin level", {15'h0, fault_pin_out}, 16'h0000);
        analog.ramping = 4'h9;
        repeat (3) @(negedge clk);
        check("ramp on enabled channel", status, 16'h5b21);
        // Writes neither alter status nor return it unasked
        frame(NOP, 1'b0, d);
        frame(NOP, 1'b0, d);
        check("write answer not status", d, 16'h0000);
        check("status after writes", status, 16'h5b21);
        @(negedge clk);
        status_on_every_write = 1'b1;
        for (int i = 0; i < 3; i++) begin
            frame(NOP, 1'b0, d);
            if (i > 0) begin
                check("status on write", d, 16'h5b21);
            end
        end
        @(negedge clk);
        status_on_every_write = 1'b0;
        analog                = '0;
        $display("test status done");

        // Check-byte mode: good read, then a read with a flipped check bit
        pec_enable = 1'b1;
        frame(rd(2'b01, 5'd9), 1'b0, d);
        frame(NOP, 1'b0, d);
        check("check mode data", d, regs.gain[1]);
        check("check byte", {8'h00, cap[7:0]}, {8'h00, spi_host_model_i.chk({LEAD_BYTE, regs.gain[1]})});
        frame(rd(2'b01, 5'd9), 1'b1, d);
        check("check error flag", {15'h0, status[ST_PEC]}, 16'h0001);
        check("fault pin on check error", {15'h0, fault_pin_oe_n}, 16'h0000);
        frame(NOP, 1'b0, d);
        check("damaged read answer", d, 16'h0000);
        check("check error cleared", {15'h0, status[ST_PEC]}, 16'h0000);
        $display("test check mode done");
        stop_test();
    end
endmodule

`default_nettype wire
